/* core/fcs_host.sv */
`timescale 1ns/1ps
// Function
// - Chip erase is sent as six writes AA/5555, 55/2AAA, 80/5555, AA/5555, 55/2AAA, 10/5555.
// - Command addresses use the low fifteen address bits and data uses the eight data lines.
// - Standard identification entry is AA/5555, 55/2AAA, 90/5555.
// - Identification exit is AA/5555, 55/2AAA, F0/5555, and each entry or exit is followed by a 10 us pause.
// - The host sends the three-write or the six-write identification entry, whichever req_op selects.
// - After power-up the host waits the same 5 ms power-up count before its first read.
// - After power-up the host waits 5 ms before its first write.
// - Byte loads of one page follow each other within 200 us, after which programming starts; the host leaves that gap to the requester.
module fcs_host #(
   parameter int PU_WRITE_CYC  = fcs_pkg::PU_WRITE_CYC,
   parameter int WRITE_CYC_CYC = fcs_pkg::WRITE_CYC_CYC,
   parameter int ERASE_CYC     = fcs_pkg::ERASE_CYC
) (
   input  wire logic        mclk,
   input  wire logic        rst_b,
   input  wire logic        req_valid,
   input  wire logic [3:0]  req_op,
   input  wire logic [15:0] req_addr,
   input  wire logic [7:0]  req_data,
   input  wire logic        req_last,
   output logic             req_ready,
   output logic             rsp_valid,
   output logic [7:0]       rsp_data,
   output logic             ce_b,
   output logic             oe_b,
   output logic             we_b,
   output logic [15:0]      addr,
   output logic [7:0]       dq_out,
   output logic             dq_oe,
   input  wire logic [7:0]  dq_in
);
   localparam int W = fcs_pkg::CNT_W;
   fcs_pkg::fcs_state_t state_r, state_nxt;
   logic [W-1:0]  tmr_r, tmr_nxt, pu_r, pu_nxt;
   logic [2:0]    step_r, step_nxt, nstep_r, nstep_nxt;
   logic [3:0]    op_r, op_nxt;
   logic          last_r, last_nxt;
   logic          ready_r, ready_nxt, rv_r, rv_nxt;
   logic [7:0]    rd_r, rd_nxt;
   logic          ce_r, ce_nxt, oe_r, oe_nxt, we_r, we_nxt, doe_r, doe_nxt;
   logic [15:0]   a_r, a_nxt;
   logic [7:0]    d_r, d_nxt;
   logic [14:0]   seq_a;
   logic [7:0]    seq_d;

   // Command step table, indexed by position in the sequence.
   always_comb begin
      seq_a = fcs_pkg::ADDR_UNLOCK1;
      seq_d = fcs_pkg::DATA_UNLOCK1;
      case (step_r)
         3'd1, 3'd4: begin
            seq_a = fcs_pkg::ADDR_UNLOCK2;
            seq_d = fcs_pkg::DATA_UNLOCK2;
         end
         3'd2: begin
            seq_d = (op_r == fcs_pkg::OP_ID_ENTRY) ? fcs_pkg::DATA_ID_ENTRY :
                    (op_r == fcs_pkg::OP_ID_EXIT)  ? fcs_pkg::DATA_ID_EXIT  : fcs_pkg::DATA_SETUP;
         end
         3'd5: begin
            seq_d = (op_r == fcs_pkg::OP_ID_ALT) ? fcs_pkg::DATA_ID_ALT : fcs_pkg::DATA_ERASE;
         end
         default: begin
            seq_a = fcs_pkg::ADDR_UNLOCK1;
         end
      endcase
   end

   always_comb begin
      state_nxt = state_r;
      tmr_nxt   = tmr_r;
      pu_nxt    = (pu_r != '0) ? pu_r - W'(1) : pu_r;
      step_nxt  = step_r;
      nstep_nxt = nstep_r;
      op_nxt    = op_r;
      last_nxt  = last_r;
      ready_nxt = 1'b0;
      rv_nxt    = 1'b0;
      rd_nxt    = rd_r;
      ce_nxt    = ce_r;
      oe_nxt    = oe_r;
      we_nxt    = we_r;
      doe_nxt   = doe_r;
      a_nxt     = a_r;
      d_nxt     = d_r;
      case (state_r)
         // writes wait for the power-up count.
         fcs_pkg::FCS_PWRUP: begin
            if (pu_r == '0) begin
               state_nxt = fcs_pkg::FCS_IDLE;
               ready_nxt = 1'b1;
            end
         end
         fcs_pkg::FCS_IDLE: begin
            ready_nxt = 1'b1;
            if (req_valid && ready_r) begin
               ready_nxt = 1'b0;
               op_nxt    = req_op;
               last_nxt  = req_last;
               step_nxt  = 3'd0;
               tmr_nxt   = W'(fcs_pkg::STROBE_CYC);
               ce_nxt    = 1'b0;
               // reads are legal once the idle state is reached.
               if (req_op == fcs_pkg::OP_READ || req_op == fcs_pkg::OP_ID_READ) begin
                  state_nxt = fcs_pkg::FCS_RSTRB;
                  oe_nxt    = 1'b0;
                  a_nxt     = (req_op == fcs_pkg::OP_ID_READ) ?
                              (req_addr[0] ? fcs_pkg::ADDR_DEV_CODE : fcs_pkg::ADDR_MFR_CODE) : req_addr;
               end else begin
                  state_nxt = fcs_pkg::FCS_WSTRB;
                  we_nxt    = 1'b0;
                  doe_nxt   = 1'b1;
                  nstep_nxt = (req_op == fcs_pkg::OP_ERASE || req_op == fcs_pkg::OP_ID_ALT) ? 3'd6 :
                              (req_op == fcs_pkg::OP_WRITE) ? 3'd1 : 3'd3;
                  a_nxt     = (req_op == fcs_pkg::OP_WRITE) ? req_addr : {1'b0, fcs_pkg::ADDR_UNLOCK1};
                  d_nxt     = (req_op == fcs_pkg::OP_WRITE) ? req_data : fcs_pkg::DATA_UNLOCK1;
               end
            end
         end
         fcs_pkg::FCS_RSTRB: begin
            tmr_nxt = tmr_r - W'(1);
            if (tmr_r == W'(1)) begin
               rd_nxt    = dq_in;
               rv_nxt    = 1'b1;
               ce_nxt    = 1'b1;
               oe_nxt    = 1'b1;
               ready_nxt = 1'b1;
               state_nxt = fcs_pkg::FCS_IDLE;
            end
         end
         fcs_pkg::FCS_WSTRB: begin
            tmr_nxt = tmr_r - W'(1);
            if (tmr_r == W'(1)) begin
               we_nxt    = 1'b1;
               ce_nxt    = 1'b1;
               step_nxt  = step_r + 3'd1;
               tmr_nxt   = W'(fcs_pkg::STROBE_CYC);
               state_nxt = fcs_pkg::FCS_WGAP;
            end
         end
         fcs_pkg::FCS_WGAP: begin
            tmr_nxt = tmr_r - W'(1);
            if (tmr_r == W'(1)) begin
               doe_nxt = 1'b0;
               if (step_r != nstep_r) begin
                  state_nxt = fcs_pkg::FCS_WSTRB;
                  tmr_nxt   = W'(fcs_pkg::STROBE_CYC);
                  ce_nxt    = 1'b0;
                  we_nxt    = 1'b0;
                  doe_nxt   = 1'b1;
                  a_nxt     = {1'b0, seq_a};
                  d_nxt     = seq_d;
               end else if (op_r == fcs_pkg::OP_WRITE && !last_r) begin
                  // ready for the next byte at once; the load window is not timed here.
                  state_nxt = fcs_pkg::FCS_IDLE;
                  ready_nxt = 1'b1;
               end else begin
                  state_nxt = fcs_pkg::FCS_WAIT;
                  tmr_nxt   = (op_r == fcs_pkg::OP_ERASE) ? W'(ERASE_CYC) :
                              (op_r == fcs_pkg::OP_WRITE) ? W'(WRITE_CYC_CYC + fcs_pkg::BLW_CYC) :
                              W'(fcs_pkg::PAUSE_CYC);
               end
            end
         end
         fcs_pkg::FCS_WAIT: begin
            tmr_nxt = tmr_r - W'(1);
            if (tmr_r == W'(1)) begin
               state_nxt = fcs_pkg::FCS_IDLE;
               ready_nxt = 1'b1;
            end
         end
         default: begin
            state_nxt = fcs_pkg::FCS_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= fcs_pkg::FCS_PWRUP;
         tmr_r   <= '0;
         pu_r    <= W'(PU_WRITE_CYC);
         step_r  <= 3'd0;
         nstep_r <= 3'd0;
         op_r    <= fcs_pkg::OP_READ;
         last_r  <= 1'b0;
         ready_r <= 1'b0;
         rv_r    <= 1'b0;
         rd_r    <= '0;
         ce_r    <= 1'b1;
         oe_r    <= 1'b1;
         we_r    <= 1'b1;
         doe_r   <= 1'b0;
         a_r     <= '0;
         d_r     <= '0;
      end else begin
         state_r <= state_nxt;
         tmr_r   <= tmr_nxt;
         pu_r    <= pu_nxt;
         step_r  <= step_nxt;
         nstep_r <= nstep_nxt;
         op_r    <= op_nxt;
         last_r  <= last_nxt;
         ready_r <= ready_nxt;
         rv_r    <= rv_nxt;
         rd_r    <= rd_nxt;
         ce_r    <= ce_nxt;
         oe_r    <= oe_nxt;
         we_r    <= we_nxt;
         doe_r   <= doe_nxt;
         a_r     <= a_nxt;
         d_r     <= d_nxt;
      end
   end

   assign req_ready = ready_r;
   assign rsp_valid = rv_r;
   assign rsp_data  = rd_r;
   assign ce_b      = ce_r;
   assign oe_b      = oe_r;
   assign we_b      = we_r;
   assign addr      = a_r;
   assign dq_out    = d_r;
   assign dq_oe     = doe_r;
endmodule

/* core/fcs_pkg.sv */
package fcs_pkg;
   localparam int         ADDR_W        = 16;
   localparam int         DATA_W        = 8;
   localparam int         CMD_ADDR_W    = 15;
   localparam logic [14:0] ADDR_UNLOCK1 = 15'h5555;
   localparam logic [14:0] ADDR_UNLOCK2 = 15'h2aaa;
   localparam logic [7:0] DATA_UNLOCK1  = 8'haa;
   localparam logic [7:0] DATA_UNLOCK2  = 8'h55;
   localparam logic [7:0] DATA_SETUP    = 8'h80;
   localparam logic [7:0] DATA_ERASE    = 8'h10;
   localparam logic [7:0] DATA_ID_ENTRY = 8'h90;
   localparam logic [7:0] DATA_ID_ALT   = 8'h60;
   localparam logic [7:0] DATA_ID_EXIT  = 8'hf0;
   localparam logic [15:0] ADDR_MFR_CODE = 16'h0000;
   localparam logic [15:0] ADDR_DEV_CODE = 16'h0001;
   localparam int         CLK_MHZ       = 100;
   localparam int         PAUSE_US      = 10;
   localparam int         PU_READ_US    = 100;
   localparam int         PU_WRITE_MS   = 5;
   localparam int         WRITE_CYC_MS  = 10;
   localparam int         ERASE_MS      = 50;
   localparam int         BYTE_LOAD_WINDOW_US = 200;
   localparam int         PAUSE_CYC     = PAUSE_US * CLK_MHZ;
   localparam int         PU_READ_CYC   = PU_READ_US * CLK_MHZ;
   localparam int         PU_WRITE_CYC  = PU_WRITE_MS * 1000 * CLK_MHZ;
   localparam int         WRITE_CYC_CYC = WRITE_CYC_MS * 1000 * CLK_MHZ;
   localparam int         ERASE_CYC     = ERASE_MS * 1000 * CLK_MHZ;
   localparam int         BLW_CYC       = BYTE_LOAD_WINDOW_US * CLK_MHZ;
   localparam int         STROBE_CYC    = 10;
   localparam logic [3:0] OP_READ       = 4'h0;
   localparam logic [3:0] OP_WRITE      = 4'h1;
   localparam logic [3:0] OP_ERASE      = 4'h2;
   localparam logic [3:0] OP_ID_ENTRY   = 4'h3;
   localparam logic [3:0] OP_ID_ALT     = 4'h4;
   localparam logic [3:0] OP_ID_EXIT    = 4'h5;
   localparam logic [3:0] OP_ID_READ    = 4'h6;
   localparam int         CNT_W         = 32;
   typedef enum logic [5:0] {
      FCS_PWRUP  = 6'h01,
      FCS_IDLE   = 6'h02,
      FCS_WSTRB  = 6'h04,
      FCS_WGAP   = 6'h08,
      FCS_RSTRB  = 6'h10,
      FCS_WAIT   = 6'h20
   } fcs_state_t;
endpackage

/* verification/fcs_host_chk.sv */
`timescale 1ns/1ps
module fcs_host_chk (
   input wire logic        mclk,
   input wire logic        rst_b,
   input wire logic        req_valid,
   input wire logic        req_ready,
   input wire logic [3:0]  req_op,
   input wire logic [15:0] req_addr,
   input wire logic        req_last,
   input wire logic        rsp_valid,
   input wire logic        ce_b,
   input wire logic        oe_b,
   input wire logic        we_b,
   input wire logic [15:0] addr,
   input wire logic [7:0]  dq_out,
   input wire logic        dq_oe
);
   wire logic tk = req_valid && req_ready;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   chk_unlock_first: assert property (tk && req_op inside {[4'h2:4'h5]}
      |=> !we_b && !ce_b && dq_oe && addr[14:0] == 15'h5555 && dq_out == 8'haa) else $error("bad unlock");
   chk_id_pause: assert property (tk && (req_op == 4'h3 || req_op == 4'h5) |-> ##300 !req_ready)
      else $error("pause cut short");
   chk_erase_busy: assert property (tk && req_op == 4'h2 |-> ##150 !req_ready)
      else $error("erase wait cut short");
   chk_id_answer: assert property (tk && req_op == 4'h6 |-> ##11 rsp_valid && oe_b)
      else $error("code read answer late");
   chk_id_addr: assert property (tk && req_op == 4'h6 |=> !oe_b && addr == {15'h0000, $past(req_addr[0])})
      else $error("code read address wrong");
   chk_page_gap: assert property (tk && req_op == 4'h1 && !req_last |-> ##[1:100] req_ready)
      else $error("page byte gap too long");
   chk_prog_wait: assert property (tk && req_op == 4'h1 && req_last |-> ##60 !req_ready)
      else $error("program wait cut short");
   chk_write_strobe: assert property ($fell(we_b) |-> !ce_b && oe_b && dq_oe)
      else $error("bad write strobes");
   chk_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
      else $error("read pulse too long");
endmodule
bind fcs_host fcs_host_chk u_chk (.mclk(mclk), .rst_b(rst_b), .req_valid(req_valid), .req_ready(req_ready),
   .req_op(req_op), .req_addr(req_addr), .req_last(req_last), .rsp_valid(rsp_valid), .ce_b(ce_b),
   .oe_b(oe_b), .we_b(we_b), .addr(addr), .dq_out(dq_out), .dq_oe(dq_oe));

/* verification/fcs_flash_model.sv */
`timescale 1ns/1ps
// The identification codes are arbitrary values.
module fcs_flash_model #(
   parameter logic [7:0] MFR_CODE = 8'h3a,
   parameter logic [7:0] DEV_CODE = 8'h7e
) (
   input  wire logic        mclk,
   input  wire logic        rst_b,
   input  wire logic        ce_b,
   input  wire logic        oe_b,
   input  wire logic        we_b,
   input  wire logic [15:0] addr,
   input  wire logic [7:0]  dq_out,
   output logic [7:0]       dq_in,
   output logic [7:0]       stat
);
   logic [2:0]  step, ers = 3'h0;
   logic [3:0]  wrs = 4'h0;
   logic        id, act;
   logic [14:0] a;
   logic [7:0]  d, val, last = 8'h00;
   assign stat = {ers, wrs, id};
   assign val = (id && addr[15:1] == 15'h0000) ? (addr[0] ? DEV_CODE : MFR_CODE) : (addr[7:0] ^ 8'h3c);
   // A deselected bus shows the inverse of the last driven byte.
   assign dq_in = (!ce_b && !oe_b) ? val : ~last;
   always @(posedge mclk) if (!ce_b && !oe_b) last <= val;
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         id <= 1'b0;
         step <= 3'h0;
         act <= 1'b0;
      end else begin
         act <= !ce_b && !we_b;
         a <= (!ce_b && !we_b) ? addr[14:0] : a;
         d <= (!ce_b && !we_b) ? dq_out : d;
         if (act && (ce_b || we_b)) begin
            step <= 3'h0;
            if ((step == 3'h0 || step == 3'h3) && a == 15'h5555 && d == 8'haa)
               step <= step + 3'h1;
            else if ((step == 3'h1 || step == 3'h4) && a == 15'h2aaa && d == 8'h55)
               step <= step + 3'h1;
            else if (step == 3'h2 && a == 15'h5555 && d == 8'h80)
               step <= 3'h3;
            else if (step == 3'h2 && a == 15'h5555 && (d == 8'h90 || d == 8'hf0))
               id <= (d == 8'h90);
            else if (step == 3'h5 && a == 15'h5555 && d == 8'h60)
               id <= 1'b1;
            // erase and program finish at once.
            else if (step == 3'h5 && a == 15'h5555 && d == 8'h10)
               ers <= ers + 3'h1;
            else
               wrs <= wrs + 4'h1;
         end
      end
   end
endmodule

/* verification/fcs_host_tb_top.sv */
`timescale 1ns/1ps
module fcs_host_tb_top;
   typedef struct packed {logic [3:0] op; logic [15:0] adr; logic [7:0] dat; logic lst; logic [7:0] exp;} fcs_row_t;
   logic        mclk = 1'b0;
   logic        rst_b = 1'b0;
   logic        req_valid = 1'b0;
   logic        req_last = 1'b0;
   logic [3:0]  req_op = 4'h0;
   logic [15:0] req_addr = 16'h0000;
   logic [7:0]  req_data = 8'h00;
   logic        req_ready, rsp_valid, ce_b, oe_b, we_b, dq_oe;
   logic [15:0] addr;
   logic [7:0]  rsp_data, dq_out, dq_in, stat, got;
   int          error_cnt = 0;
   int          checks_done = 0;
   int          cyc = 0;
   int          n;
   fcs_row_t    rows [13];
   always #5 mclk = ~mclk;
   fcs_host #(.PU_WRITE_CYC(20), .WRITE_CYC_CYC(50), .ERASE_CYC(50)) u_dut (.mclk(mclk), .rst_b(rst_b),
      .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr), .req_data(req_data), .req_last(req_last),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .ce_b(ce_b), .oe_b(oe_b), .we_b(we_b),
      .addr(addr), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
   fcs_flash_model #(.MFR_CODE(8'h3a), .DEV_CODE(8'h7e)) u_flash (.mclk(mclk), .rst_b(rst_b), .ce_b(ce_b),
      .oe_b(oe_b), .we_b(we_b), .addr(addr), .dq_out(dq_out), .dq_in(dq_in), .stat(stat));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Sends one request and waits until the block is idle again.
   task automatic run(input fcs_row_t r);
      got = 8'hxx;
      do @(negedge mclk); while (req_ready !== 1'b1);
      @(posedge mclk);
      req_op <= r.op;
      req_addr <= r.adr;
      req_data <= r.dat;
      req_last <= r.lst;
      req_valid <= 1'b1;
      @(posedge mclk);
      req_valid <= 1'b0;
      do begin
         @(negedge mclk);
         if (rsp_valid === 1'b1) got = rsp_data;
      end while (req_ready !== 1'b1);
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 60000) begin
         error_cnt++;
         $display("[ERR] %0t timeout", $time);
         end_of_test();
      end
   end
   initial begin
      rows = '{'{4'h0, 16'h1234, 8'h00, 1'b0, 8'h08}, '{4'h3, 16'h0000, 8'h00, 1'b0, 8'h01},
               '{4'h6, 16'h0000, 8'h00, 1'b0, 8'h3a}, '{4'h6, 16'h0001, 8'h00, 1'b0, 8'h7e},
               '{4'h5, 16'h0000, 8'h00, 1'b0, 8'h00}, '{4'h4, 16'h0000, 8'h00, 1'b0, 8'h01},
               '{4'h6, 16'hffff, 8'h00, 1'b0, 8'h7e}, '{4'h5, 16'h0000, 8'h00, 1'b0, 8'h00},
               '{4'h2, 16'h0000, 8'h00, 1'b0, 8'h20}, '{4'h1, 16'h0100, 8'ha5, 1'b0, 8'h22},
               '{4'h1, 16'h017f, 8'h5a, 1'b1, 8'h24}, '{4'h1, 16'h5555, 8'haa, 1'b0, 8'h24},
               '{4'h1, 16'h5555, 8'h90, 1'b1, 8'h26}};
      repeat (12) @(posedge mclk);
      rst_b <= 1'b1;
      foreach (rows[i]) begin
         run(rows[i]);
         if (rows[i].op == 4'h0 || rows[i].op == 4'h6)
            check(got, rows[i].exp);
         else
            check(stat, rows[i].exp);
         $display("row %0d done", i);
      end
      run(fcs_row_t'{4'h3, 16'h0000, 8'h00, 1'b0, 8'h00});
      @(posedge mclk);
      rst_b <= 1'b0;
      repeat (12) @(posedge mclk);
      rst_b <= 1'b1;
      n = 0;
      do begin
         @(negedge mclk);
         n++;
      end while (req_ready !== 1'b1 && n < 100);
      check(8'(n >= 20 && n < 100), 8'h01);
      run(fcs_row_t'{4'h6, 16'h0000, 8'h00, 1'b0, 8'h00});
      check(got, 8'h3c);
      $display("power loss test done");
      end_of_test();
   end
endmodule
